// ==== rtl/iss_defines.svh ====
/*
 * offsets, field positions, reset values and timing counts of the
 * inertial sensor spi frame block.
 * assumes inclusion by bare name and a 20 MHz block clock.
 */
`ifndef ISS_DEFINES_SVH
`define ISS_DEFINES_SVH

// block clock and internal sample rate
`define ISS_MCLK_HZ 20000000
`define ISS_SAMPLE_RATE_HZ 8000
`define ISS_SAMPLE_CYCLES (`ISS_MCLK_HZ / `ISS_SAMPLE_RATE_HZ)

// frame layout
`define ISS_FRAME_BITS 6'h20
`define ISS_MODE_DATA 3'h5
`define ISS_REPLY_FILL 2'h2
`define ISS_ERR_NONE 2'h2
`define ISS_ERR_ALARM 2'h1
`define ISS_FIXED_VALUE 16'hAA55

// check code: x^4+1, initial value
`define ISS_CRC_INIT 4'hA
`define ISS_CRC_POLY 4'h1

// selector codes
`define ISS_SEL_TEMP_1 4'hC
`define ISS_SEL_TEMP_2 4'hD
`define ISS_SEL_TEMP_DIFF 4'hE
`define ISS_SEL_FIXED 4'hF

// register offsets
`define ISS_REG_STATUS 4'h0
`define ISS_REG_MASK 4'h4
`define ISS_REG_CTRL 4'h8
`define ISS_REG_LAST_CMD 4'hC

// status bits
`define ISS_ST_FRAME_OK 0
`define ISS_ST_FRAME_BAD 1
`define ISS_ST_UNKNOWN 2
`define ISS_ST_WIDTH 3

// reset values
`define ISS_MASK_RST 3'h0
`define ISS_CTRL_RST 1'h0

`endif

// ==== rtl/iss_pkg.sv ====
/*
 * types of the inertial sensor spi frame block.
 * assumes nothing beyond a systemverilog compiler.
 */
package iss_pkg;
	// frame engine states
	typedef enum logic [0:0] {
		ISS_IDLE = 1'b0,
		ISS_ACTIVE = 1'b1
	} iss_state_t;
endpackage : iss_pkg

// ==== rtl/iss_sync.sv ====
/*
 * two flip-flop synchroniser for a group of pin inputs.
 * assumes the inputs are levels from outside the mclk domain; the
 * reset value must equal the idle level of each pin, or a false edge
 * or a false pin reset follows the release of rst.
 */
`timescale 1ns/1ns
`default_nettype none
module iss_sync #(
	parameter int W = 4,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg; // first stage, read only by q

	// two stages, reset to the idle pin levels
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_reg <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : iss_sync
`default_nettype wire

// ==== rtl/iss_spi_frame.sv ====
/*
 * spi slave frame logic of a six-axis inertial sensor: command capture,
 * check code, out-of-frame data reply, sample acquisition and a small
 * register port with interrupt.
 * assumes pins sclk, frame_select_n, mosi and hardware_reset_n are
 * asynchronous to mclk and sclk is far slower than mclk.
 */
`timescale 1ns/1ns
`default_nettype none
`include "iss_defines.svh"

// Overview of operation
// - one frame needs 32 clocks, clocks after the 32nd are ignored
// - reply comes out in the next frame
// - reply register updated at frame select rise
// - internal samples renewed 8000 times per second
// - reply bits 31:16 carry signed sample
// - selector decode, odd low codes reserved
// - msb first, sample rising, change falling
// - miso released while frame select high
// - 4-bit check code x^4+1, start 0xA
// - acquire bit captures at next select fall
module iss_spi_frame #(
	parameter int SAMPLE_CYCLES = `ISS_SAMPLE_CYCLES
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic frame_select_n,
	input wire logic mosi,
	input wire logic hardware_reset_n,
	output logic miso_out,
	output logic miso_oe_n,
	input wire logic [15:0] rate_x,
	input wire logic [15:0] rate_y,
	input wire logic [15:0] rate_z,
	input wire logic [15:0] accel_x,
	input wire logic [15:0] accel_y,
	input wire logic [15:0] accel_z,
	input wire logic [15:0] temp_1,
	input wire logic [15:0] temp_2,
	input wire logic safety_alarm,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq
);
	import iss_pkg::*;

	// check code over 28 bits, msb first
	function automatic logic [3:0] crc28(input logic [27:0] d);
		logic [3:0] c;
		logic fb;
		c = `ISS_CRC_INIT;
		for (int i = 27; i >= 0; i--) begin
			fb = c[3] ^ d[i];
			c = {c[2:0], 1'b0} ^ (fb ? `ISS_CRC_POLY : 4'h0);
		end
		return c;
	endfunction : crc28

	logic sclk_s, ncs_s, mosi_s, hwrst_n_s; // synchronised pins
	logic sclk_d_reg; // previous synchronised serial clock
	iss_state_t state_reg, state_next; // frame engine state
	logic [5:0] cnt_reg, cnt_next; // rising clocks seen in frame
	logic [31:0] rx_reg, rx_next; // command shift register
	logic [31:0] tx_reg, tx_next; // reply shift register
	logic [31:0] reply_reg, reply_next; // reply for next frame
	logic [15:0] live_reg [8]; // latest internal samples
	logic [15:0] live_next [8];
	logic [15:0] held_reg [8]; // samples frozen for replies
	logic [15:0] held_next [8];
	logic [15:0] samp_in [8]; // sample ports as array
	logic [1:0] kact_reg, kact_next; // keep-alive counter
	logic acq_reg, acq_next; // capture pending at next frame
	logic [11:0] tick_cnt_reg, tick_cnt_next; // sample rate divider
	logic [`ISS_ST_WIDTH-1:0] status_reg, status_next; // sticky events
	logic [`ISS_ST_WIDTH-1:0] mask_reg, mask_next; // interrupt mask
	logic ctrl_reg, ctrl_next; // forced alarm bit
	logic [31:0] last_reg, last_next; // last accepted command
	logic [31:0] rdata_next; // read data next value
	logic sclk_rise, sclk_fall, frame_end, hw_clear; // decoded events
	logic cmd_ok, cmd_known, alarm; // frame checks
	logic [`ISS_ST_WIDTH-1:0] ev; // events this cycle
	logic [15:0] sel_val; // selected sample value
	logic [3:0] sel; // selector of received command
	logic [27:0] reply_body; // reply before check code

	// pins into the mclk domain
	// idle levels: clock low, select high, data low, pin reset high
	iss_sync #(.W(4), .RST_VAL(4'h5)) u_sync (
		.mclk(mclk),
		.rst(rst),
		.d({sclk, frame_select_n, mosi, hardware_reset_n}),
		.q({sclk_s, ncs_s, mosi_s, hwrst_n_s})
	);

	assign samp_in[0] = rate_x;
	assign samp_in[1] = rate_y;
	assign samp_in[2] = rate_z;
	assign samp_in[3] = accel_x;
	assign samp_in[4] = accel_y;
	assign samp_in[5] = accel_z;
	assign samp_in[6] = temp_1;
	assign samp_in[7] = temp_2;

	// edge decode on synchronised pins
	always_comb begin
		sclk_rise = sclk_s & ~sclk_d_reg;
		sclk_fall = ~sclk_s & sclk_d_reg;
		frame_end = (state_reg == ISS_ACTIVE) & ncs_s;
		hw_clear = ~hwrst_n_s;
		alarm = safety_alarm | ctrl_reg;
		sel = rx_reg[11:8];
	end

	// frame checks on the received command
	always_comb begin
		cmd_ok = (cnt_reg == `ISS_FRAME_BITS) &&
			(crc28(rx_reg[31:4]) == rx_reg[3:0]) &&
			(rx_reg[15:13] == `ISS_MODE_DATA);
		cmd_known = (rx_reg[31:16] == 16'h0000) && !rx_reg[12] &&
			(rx_reg[6:4] == 3'h0) &&
			!(sel[0] && !(sel[3] && sel[2]));
	end

	// selector decode from frozen samples
	always_comb begin
		case (sel)
		`ISS_SEL_TEMP_1: sel_val = held_reg[6];
		`ISS_SEL_TEMP_2: sel_val = held_reg[7];
		`ISS_SEL_TEMP_DIFF: sel_val = held_reg[6] - held_reg[7];
		`ISS_SEL_FIXED: sel_val = `ISS_FIXED_VALUE;
		default: sel_val = held_reg[sel[3:1]];
		endcase
		reply_body = {sel_val,
			alarm ? `ISS_ERR_ALARM : `ISS_ERR_NONE,
			`ISS_REPLY_FILL, sel,
			rx_reg[7], 1'b0, kact_reg};
	end

	// frame engine next state
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		rx_next = rx_reg;
		tx_next = tx_reg;
		reply_next = reply_reg;
		kact_next = kact_reg;
		acq_next = acq_reg;
		last_next = last_reg;
		held_next = held_reg;
		live_next = live_reg;
		ev = '0;
		tick_cnt_next = tick_cnt_reg + 12'h001;
		// sample divider, free of the serial clock
		if (tick_cnt_reg == 12'(SAMPLE_CYCLES - 1)) begin
			tick_cnt_next = 12'h000;
			live_next = samp_in;
		end
		case (state_reg)
		ISS_IDLE: begin
			if (!ncs_s) begin
				state_next = ISS_ACTIVE;
				cnt_next = 6'h00;
				tx_next = reply_reg;
				if (acq_reg) begin
					held_next = live_reg;
					acq_next = 1'b0;
				end
			end
		end
		ISS_ACTIVE: begin
			if (frame_end) begin
				state_next = ISS_IDLE;
				if (!cmd_ok) begin
					ev[`ISS_ST_FRAME_BAD] = 1'b1;
				end else if (!cmd_known) begin
					ev[`ISS_ST_UNKNOWN] = 1'b1;
				end else begin
					ev[`ISS_ST_FRAME_OK] = 1'b1;
					last_next = rx_reg;
					acq_next = rx_reg[7];
					kact_next = kact_reg + 2'h1;
					reply_next = {reply_body, crc28(reply_body)};
				end
			end else begin
				if (sclk_rise && cnt_reg != `ISS_FRAME_BITS) begin
					rx_next = {rx_reg[30:0], mosi_s};
					cnt_next = cnt_reg + 6'h01;
				end
				if (sclk_fall && cnt_reg != 6'h00) begin
					tx_next = {tx_reg[30:0], 1'b0};
				end
			end
		end
		default: state_next = ISS_IDLE;
		endcase
		// pin reset clears frame state, samples and counters
		if (hw_clear) begin
			state_next = ISS_IDLE;
			cnt_next = 6'h00;
			rx_next = 32'h0000_0000;
			tx_next = 32'h0000_0000;
			reply_next = 32'h0000_0000;
			kact_next = 2'h0;
			acq_next = 1'b0;
			last_next = 32'h0000_0000;
			tick_cnt_next = 12'h000;
			live_next = '{default: 16'h0000};
			held_next = '{default: 16'h0000};
		end
	end

	// frame engine registers; pin reset is handled in the next values
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg <= ISS_IDLE;
			sclk_d_reg <= 1'b0;
			cnt_reg <= 6'h00;
			rx_reg <= 32'h0000_0000;
			tx_reg <= 32'h0000_0000;
			reply_reg <= 32'h0000_0000;
			kact_reg <= 2'h0;
			acq_reg <= 1'b0;
			last_reg <= 32'h0000_0000;
			tick_cnt_reg <= 12'h000;
			for (int i = 0; i < 8; i++) begin
				live_reg[i] <= 16'h0000;
				held_reg[i] <= 16'h0000;
			end
		end else begin
			state_reg <= state_next;
			sclk_d_reg <= sclk_s;
			cnt_reg <= cnt_next;
			rx_reg <= rx_next;
			tx_reg <= tx_next;
			reply_reg <= reply_next;
			kact_reg <= kact_next;
			acq_reg <= acq_next;
			last_reg <= last_next;
			tick_cnt_reg <= tick_cnt_next;
			live_reg <= live_next;
			held_reg <= held_next;
		end
	end

	// pin drive: msb of shifter, released outside frames
	always_comb begin
		miso_out = tx_reg[31];
		miso_oe_n = (state_reg != ISS_ACTIVE);
	end

	// register port next values; event set wins over read clear
	always_comb begin
		status_next = status_reg;
		mask_next = mask_reg;
		ctrl_next = ctrl_reg;
		rdata_next = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
			`ISS_REG_STATUS: begin
				rdata_next = 32'(status_reg);
				status_next = '0;
			end
			`ISS_REG_MASK: rdata_next = 32'(mask_reg);
			`ISS_REG_CTRL: rdata_next = 32'(ctrl_reg);
			`ISS_REG_LAST_CMD: rdata_next = last_reg;
			default: rdata_next = 32'h0000_0000;
			endcase
		end
		if (reg_wr) begin
			case (reg_addr)
			`ISS_REG_MASK: mask_next = reg_wdata[`ISS_ST_WIDTH-1:0];
			`ISS_REG_CTRL: ctrl_next = reg_wdata[0];
			default: ;
			endcase
		end
		status_next = status_next | ev;
	end

	// register port flops
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			status_reg <= '0;
			mask_reg <= `ISS_MASK_RST;
			ctrl_reg <= `ISS_CTRL_RST;
			reg_rdata <= 32'h0000_0000;
		end else begin
			status_reg <= status_next;
			mask_reg <= mask_next;
			ctrl_reg <= ctrl_next;
			reg_rdata <= rdata_next;
		end
	end

	// level interrupt from unmasked sticky bits
	always_comb begin
		irq = |(status_reg & mask_reg);
	end
endmodule : iss_spi_frame
`default_nettype wire

// ==== testbench/iss_spi_frame_properties.sv ====
/* port checker of the spi frame block.
   assumes it is bound to every iss_spi_frame instance. */
`timescale 1ns/1ns
`default_nettype none
module iss_spi_frame_properties (
	input wire logic mclk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic frame_select_n,
	input wire logic miso_out,
	input wire logic miso_oe_n,
	input wire logic [3:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_drive_start: assert property ($fell(frame_select_n)
		|-> ##[1:5] !miso_oe_n) else $error("miso not driven");
	a_drive_hold: assert property (!miso_oe_n && !frame_select_n
		|=> !miso_oe_n) else $error("miso dropped in frame");
	a_drive_cause: assert property ($fell(miso_oe_n)
		|-> $past(!frame_select_n, 2)) else $error("miso driven unselected");
	a_release_end: assert property ($rose(frame_select_n)
		|-> ##[1:5] miso_oe_n) else $error("miso not released");
	a_release_idle: assert property (frame_select_n[*5]
		|-> miso_oe_n) else $error("miso driven while idle");
	a_bit_stable: assert property ((sclk && !frame_select_n)[*3]
		|-> $stable(miso_out)) else $error("miso moved while clock high");
	a_rdata_idle: assert property (!$past(reg_rd)
		|-> reg_rdata == 32'h0) else $error("read data outside read");
	a_unmapped_zero: assert property (reg_rd && reg_addr == 4'h1
		|=> reg_rdata == 32'h0) else $error("unmapped read not zero");
endmodule : iss_spi_frame_properties
bind iss_spi_frame iss_spi_frame_properties iss_spi_frame_properties_i (
	.mclk, .rst, .sclk, .frame_select_n, .miso_out, .miso_oe_n,
	.reg_addr, .reg_rd, .reg_rdata);
`default_nettype wire

// ==== testbench/iss_host_model.sv ====
/* host master model: frames of n clocks, 400 ns serial clock.
   assumes miso_oe_n low while the device drives miso. */
`timescale 1ns/1ns
`default_nettype none
module iss_host_model (
	output logic sclk,
	output logic frame_select_n,
	output logic mosi,
	input wire logic miso_out,
	input wire logic miso_oe_n
);
	// a released line shows the inverse, there is no pull
	wire miso_line = miso_oe_n ? ~miso_out : miso_out;
	// idle levels, clock stands low outside frames
	initial begin
		sclk = 1'h0;
		frame_select_n = 1'h1;
		mosi = 1'h0;
	end
	// one frame, msb first, sample on rise, change on fall
	task automatic xfer(input logic [31:0] c, input int n,
		output logic [31:0] r);
		r = 32'h0;
		#2; // keep the select edge off the block clock edge
		frame_select_n = 1'h0;
		mosi = c[31];
		#213;
		for (int i = 1; i <= n; i++) begin
			sclk = 1'h1;
			r = {r[30:0], miso_line};
			#200;
			sclk = 1'h0;
			if (i < 32) mosi = c[31-i];
			#200;
		end
		#38; // clock held low past the select hold guard
		frame_select_n = 1'h1;
		mosi = ~mosi;
		#1000;
	endtask : xfer
endmodule : iss_host_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
/* self-checking bench of the spi frame block.
   assumes the checker and host model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	err_total++; $display("wrong value %s exp %h seen %h", n, e, g); end end
module tb_top;
	import iss_pkg::*;
	logic mclk, rst, sclk, frame_select_n, mosi, miso_out, miso_oe_n, irq;
	logic safety_alarm, reg_wr, reg_rd, rd_d, px2;
	logic hw_rst_n; // pin reset, active low
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, got, ev_v, rx, nxt, lc, rng;
	logic [15:0] sv [8]; // live sample inputs
	logic [15:0] hv [8]; // expected held set
	logic [31:0] q [$]; // expected results
	logic [1:0] kc; // expected keep-alive count
	int err_total, cmp_count, cyc;
	event ev;
	iss_spi_frame #(.SAMPLE_CYCLES(20)) iss_spi_frame_i (.mclk, .rst,
		.sclk, .frame_select_n, .mosi, .hardware_reset_n(hw_rst_n), .miso_out,
		.miso_oe_n, .rate_x(sv[0]), .rate_y(sv[1]), .rate_z(sv[2]),
		.accel_x(sv[3]), .accel_y(sv[4]), .accel_z(sv[5]), .temp_1(sv[6]),
		.temp_2(sv[7]), .safety_alarm, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .irq);
	iss_host_model iss_host_model_i (.sclk, .frame_select_n, .mosi,
		.miso_out, .miso_oe_n);
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs
	// nibble fold equals x^4+1 over 28 bits
	function automatic logic [3:0] crc(input logic [31:0] w);
		crc = 4'hA;
		for (int i = 1; i < 8; i++) crc ^= w[i*4 +: 4];
	endfunction : crc
	function automatic logic [15:0] dat(input logic [3:0] s);
		case (s)
			4'hC: return hv[6];
			4'hD: return hv[7];
			4'hE: return hv[6] - hv[7];
			4'hF: return 16'hAA55;
			default: return hv[s[3:1]];
		endcase
	endfunction : dat
	function automatic logic [31:0] rep(input logic [3:0] s,
		input logic a, input logic x);
		rep = {dat(s), a ? 2'h1 : 2'h2, 2'h2, s, x, 1'h0, kc, 4'h0};
		rep[3:0] = crc(rep);
	endfunction : rep
	task automatic see(input logic [31:0] g);
		got = g;
		-> ev;
	endtask : see
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge mclk);
		reg_wr <= 1'h0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		q.push_back(e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge mclk);
		reg_rd <= 1'h0;
	endtask : rd
	task automatic irqchk(input logic e);
		@(posedge mclk);
		#1;
		q.push_back({31'h0, e});
		see({31'h0, irq});
	endtask : irqchk
	// one frame: expect the reply prepared by the last accepted command
	task automatic send(input logic [3:0] s, input logic x, input int n,
		input logic [3:0] bad);
		logic [31:0] c;
		logic a;
		c = xs();
		a = c[9];
		c = {16'h0, 3'h5, 1'h0, s, x, 7'h0};
		c[3:0] = crc(c) ^ bad;
		@(posedge mclk);
		safety_alarm <= a;
		if (px2) hv = sv;
		q.push_back(nxt >> (32 - n));
		iss_host_model_i.xfer(c, n, rx);
		see(rx);
		if (n == 32 && bad == 4'h0 && (!s[0] || s > 4'hB)) begin
			nxt = rep(s, a, x);
			kc++;
			lc = c;
			px2 = x;
		end
	endtask : send
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results
	// result watchers
	always @(ev) begin
		ev_v = q.pop_front();
		`CHK("result", ev_v, got)
	end
	always @(posedge mclk) begin
		if (rd_d) see(reg_rdata);
		rd_d <= reg_rd;
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			results();
		end
	end
	initial begin
		mclk = 1'h0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		{rst, reg_wr, reg_rd, safety_alarm, px2} = 5'h10;
		hw_rst_n = 1'h1; // never pulsed, held high for the whole run
		{reg_addr, reg_wdata, nxt, kc} = '0;
		rng = 32'hB700;
		foreach (sv[i]) sv[i] = xs();
		repeat (10) @(posedge mclk);
		rst <= 1'h0;
		wr(4'h4, 32'h2);
		rd(4'h4, 32'h2);
		rd(4'h1, 32'h0);
		wr(4'h8, 32'h1);
		rd(4'h8, 32'h1);
		wr(4'h8, 32'h0);
		$display("registers done");
		send(4'hF, 1'h1, 32, 4'h0);
		for (int s = 0; s < 16; s++) if (!s[0] || s > 11) begin
			send(s[3:0], 1'h0, 32, 4'h0);
			@(posedge mclk);
			foreach (sv[i]) sv[i] <= xs();
		end
		rd(4'h0, 32'h1);
		rd(4'h0, 32'h0);
		rd(4'hC, lc);
		$display("selectors done");
		send(4'hF, 1'h0, 31, 4'h0);
		send(4'hF, 1'h0, 32, 4'h1);
		irqchk(1'h1);
		rd(4'h0, 32'h2);
		irqchk(1'h0);
		$display("bad frames done");
		for (int s = 1; s < 12; s += 2) send(s[3:0], 1'h0, 32, 4'h0);
		send(4'hF, 1'h0, 32, 4'h0);
		irqchk(1'h0);
		rd(4'h0, 32'h5);
		$display("reserved done");
		results();
	end
endmodule : tb_top
`default_nettype wire
